// file: inc/psel_defs.svh
`ifndef PSEL_DEFS_SVH
`define PSEL_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PSEL_IDX_SRC       12'hA00
`define PSEL_IDX_PPR       12'hA01
`define PSEL_IDX_FBT       12'hA02
`define PSEL_IDX_CMDT      12'hA10
`define PSEL_IDX_GNUM      12'hA11
`define PSEL_IDX_GDEN      12'hA12
`define PSEL_IDX_FILT      12'hA15
`define PSEL_IDX_CSRC      12'hA20
`define PSEL_IDX_IFN       12'hA21
`define PSEL_IDX_MODE      12'hA22
`define PSEL_IDX_CTRL      12'hA23
`define PSEL_IDX_STAT      12'hA24
`define PSEL_IDX_SPEED     12'hA25
`define PSEL_IDX_POS       12'hA26

`define PSEL_RST_SRC       16'h0000
`define PSEL_RST_PPR       16'h0258
`define PSEL_RST_FBT       16'h0000
`define PSEL_RST_CMDT      16'h0000
`define PSEL_RST_GEAR      16'h0001
`define PSEL_RST_FILT      16'h0000
`define PSEL_RST_CSRC      16'h0000
`define PSEL_RST_IFN       16'h0000
`define PSEL_RST_MODE      16'h0000

`define PSEL_SRC_OFF       16'h0000
`define PSEL_SRC_CARD      16'h0001
`define PSEL_SRC_TERM      16'h0005
`define PSEL_PPR_MIN       16'h0001
`define PSEL_PPR_MAX       16'h4E20
`define PSEL_TYPE_TWO_MIN  16'h0001
`define PSEL_TYPE_TWO_MAX  16'h0004
`define PSEL_TYPE_SINGLE   16'h0005
`define PSEL_CSRC_PULSE    16'h0004
`define PSEL_IFN_PULSE     16'h0000
`define PSEL_FILT_MAX      16'h028F
// Control modes 0..4 are the open-loop and sensorless set.
`define PSEL_MODE_VHZ      16'h0000
`define PSEL_MODE_VHZ_FB   16'h0001
`define PSEL_MODE_SVC      16'h0002
`define PSEL_MODE_FOC_SL   16'h0003
`define PSEL_MODE_TQC_SL   16'h0004
`define PSEL_MODE_FOC_PG   16'h0005
`define PSEL_MODE_TQC_PG   16'h0006
`define PSEL_CTRL_APPLY    0

`define PSEL_CLK_HZ        48'h1312D00
`define PSEL_CLK_NS        32'h32
`define PSEL_CHZ_SCALE     48'h64
`define PSEL_FILT_TICK_NS  32'hF4240
`define PSEL_FILT_MS       64'h64
`define PSEL_STOP_NS       32'h3B9ACA00
`define PSEL_RECIP_ONE     48'h1000000

`endif

// file: inc/psel_pkg.sv
package psel_pkg;
  typedef enum logic [3:0] {
    RG_SRC, RG_PPR, RG_FBT, RG_CMDT, RG_GNUM, RG_GDEN, RG_FILT,
    RG_CSRC, RG_IFN, RG_MODE, RG_CTRL, RG_STAT, RG_SPEED, RG_POS,
    RG_NONE
  } psel_reg_t;
  typedef enum logic {DV_IDLE, DV_RUN} psel_div_st_t;
  typedef enum logic {JOB_RATE, JOB_RECIP} psel_job_t;
endpackage : psel_pkg

// file: inc/psel_qd_if.sv
`timescale 1ns/10ps
interface psel_qd_if;
  logic en;
  logic two_phase;
  logic step;
  logic dir;
  modport dec (input en, input two_phase, output step, output dir);
  modport ctl (output en, output two_phase, input step, input dir);
endinterface : psel_qd_if

// file: logic/psel_quad_decoder.sv
`timescale 1ns/10ps
module psel_quad_decoder (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pulse_in_a,
  input  wire logic pulse_in_b,
  psel_qd_if.dec    qd
);
  logic a_q_r;
  logic b_q_r;
  wire  a_rise = pulse_in_a & ~a_q_r;
  wire  b_rise = pulse_in_b & ~b_q_r;

  // Every edge is seen in one cycle, far above the terminal pulse limit.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      a_q_r   <= 1'b0;
      b_q_r   <= 1'b0;
      qd.step <= 1'b0;
      qd.dir  <= 1'b1;
    end
    else
    begin
      a_q_r <= pulse_in_a;
      b_q_r <= pulse_in_b;
      if (!qd.en)
        qd.step <= 1'b0;
      else if (qd.two_phase)
      begin
        // Only the A rise counts, so a full A/B cycle is one pulse.
        qd.step <= a_rise;
        if (a_rise)
          qd.dir <= ~pulse_in_b;
      end
      else
      begin
        qd.step <= b_rise;
        qd.dir  <= 1'b1;
      end
    end
  end
endmodule : psel_quad_decoder

// file: logic/psel_top.sv
`timescale 1ns/10ps
`include "psel_defs.svh"

module psel_top #(
  parameter int ADDR_W        = 16,
  parameter int FILT_TICK_CYC = `PSEL_FILT_TICK_NS / `PSEL_CLK_NS,
  parameter int STOP_CYC      = `PSEL_STOP_NS / `PSEL_CLK_NS
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  input  wire logic              pulse_in_a,
  input  wire logic              pulse_in_b,
  input  wire logic              card_step,
  input  wire logic              card_dir,
  output wire logic              pulse_a_func_en,
  output wire logic [31:0]       speed_fb_chz,
  output wire logic              speed_fb_valid,
  output wire logic [31:0]       speed_cmd_chz,
  output wire logic              speed_cmd_valid,
  output wire logic              speed_dir
);
  localparam int CW = $clog2(STOP_CYC + 1);
  localparam int TW = $clog2(FILT_TICK_CYC);

  logic [15:0] src_r, ppr_r, fbt_r, cmdt_r, gnum_r, gden_r, filt_r;
  logic [15:0] csrc_r, ifn_r, mode_r, src_act_r, ppr_act_r, fbt_act_r;
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic              aw_have_r, w_have_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r, w_data_r;
  logic [3:0]        w_strb_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [15:0]       wcur, wv;
  logic [31:0]       rval;
  logic              wok, rok;

  function automatic psel_pkg::psel_reg_t reg_dec(
    input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:14] != '0)
      return psel_pkg::RG_NONE;
    case (a[13:2])
      `PSEL_IDX_SRC:   return psel_pkg::RG_SRC;
      `PSEL_IDX_PPR:   return psel_pkg::RG_PPR;
      `PSEL_IDX_FBT:   return psel_pkg::RG_FBT;
      `PSEL_IDX_CMDT:  return psel_pkg::RG_CMDT;
      `PSEL_IDX_GNUM:  return psel_pkg::RG_GNUM;
      `PSEL_IDX_GDEN:  return psel_pkg::RG_GDEN;
      `PSEL_IDX_FILT:  return psel_pkg::RG_FILT;
      `PSEL_IDX_CSRC:  return psel_pkg::RG_CSRC;
      `PSEL_IDX_IFN:   return psel_pkg::RG_IFN;
      `PSEL_IDX_MODE:  return psel_pkg::RG_MODE;
      `PSEL_IDX_CTRL:  return psel_pkg::RG_CTRL;
      `PSEL_IDX_STAT:  return psel_pkg::RG_STAT;
      `PSEL_IDX_SPEED: return psel_pkg::RG_SPEED;
      `PSEL_IDX_POS:   return psel_pkg::RG_POS;
      default:         return psel_pkg::RG_NONE;
    endcase
  endfunction : reg_dec

  psel_pkg::psel_reg_t wsel, rsel;
  assign wsel = reg_dec(aw_addr_r);
  assign rsel = reg_dec(araddr);

  wire aw_take = awvalid & awready_r;
  wire w_take  = wvalid & wready_r;
  wire ar_take = arvalid & arready_r;
  wire wr_go   = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_do   = wr_go & wok;
  wire apply   = wr_do & (wsel == psel_pkg::RG_CTRL) & wv[`PSEL_CTRL_APPLY];
  wire aw_nxt  = ~wr_go & (aw_have_r | aw_take);
  wire w_nxt   = ~wr_go & (w_have_r | w_take);

  // Path selection from the applied source settings.
  wire mode_ok  = mode_r <= `PSEL_MODE_TQC_SL;
  wire fbt_two  = (fbt_act_r >= `PSEL_TYPE_TWO_MIN) &&
                  (fbt_act_r <= `PSEL_TYPE_TWO_MAX);
  wire cmdt_two = (cmdt_r >= `PSEL_TYPE_TWO_MIN) &&
                  (cmdt_r <= `PSEL_TYPE_TWO_MAX);
  wire term_src = src_act_r == `PSEL_SRC_TERM;
  wire card_src = src_act_r == `PSEL_SRC_CARD;
  wire cmd_on   = csrc_r == `PSEL_CSRC_PULSE;
  wire fb_term  = term_src & mode_ok &
                  (fbt_two | (fbt_act_r == `PSEL_TYPE_SINGLE));
  wire cmd_one  = cmd_on & term_src & ~fb_term &
                  (ifn_r == `PSEL_IFN_PULSE) &
                  (cmdt_r == `PSEL_TYPE_SINGLE);
  wire cmd_two  = cmd_on & (src_act_r == `PSEL_SRC_OFF) & cmdt_two;
  wire cmd_card = cmd_on & card_src & cmdt_two;
  wire fb_path  = fb_term | (card_src & ~cmd_card);
  wire cmd_path = cmd_one | cmd_two | cmd_card;

  psel_qd_if qd_bus ();
  assign qd_bus.en        = fb_term | cmd_one | cmd_two;
  assign qd_bus.two_phase = fb_term ? fbt_two : cmd_two;

  psel_quad_decoder u_dec (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pulse_in_a (pulse_in_a),
    .pulse_in_b (pulse_in_b),
    .qd         (qd_bus)
  );

  wire step = card_src ? card_step : qd_bus.step;
  wire dir  = card_src ? card_dir : qd_bus.dir;

  always_comb
  begin
    wcur = 16'h0000;
    wok  = 1'b1;
    case (wsel)
      psel_pkg::RG_SRC:  wcur = src_r;
      psel_pkg::RG_PPR:  wcur = ppr_r;
      psel_pkg::RG_FBT:  wcur = fbt_r;
      psel_pkg::RG_CMDT: wcur = cmdt_r;
      psel_pkg::RG_GNUM: wcur = gnum_r;
      psel_pkg::RG_GDEN: wcur = gden_r;
      psel_pkg::RG_FILT: wcur = filt_r;
      psel_pkg::RG_CSRC: wcur = csrc_r;
      psel_pkg::RG_IFN:  wcur = ifn_r;
      psel_pkg::RG_MODE: wcur = mode_r;
      default:           wcur = 16'h0000;
    endcase
    wv = {w_strb_r[1] ? w_data_r[15:8] : wcur[15:8],
          w_strb_r[0] ? w_data_r[7:0] : wcur[7:0]};
    // Out-of-range settings are refused and the old value is kept.
    case (wsel)
      psel_pkg::RG_SRC:  wok = (wv == `PSEL_SRC_OFF) ||
                               (wv == `PSEL_SRC_CARD) ||
                               (wv == `PSEL_SRC_TERM);
      psel_pkg::RG_PPR:  wok = (wv >= `PSEL_PPR_MIN) &&
                               (wv <= `PSEL_PPR_MAX);
      psel_pkg::RG_FBT:  wok = wv <= `PSEL_TYPE_SINGLE;
      psel_pkg::RG_CMDT: wok = wv <= `PSEL_TYPE_SINGLE;
      psel_pkg::RG_GNUM: wok = wv != 16'h0000;
      psel_pkg::RG_GDEN: wok = wv != 16'h0000;
      psel_pkg::RG_FILT: wok = wv <= `PSEL_FILT_MAX;
      psel_pkg::RG_MODE: wok = wv <= `PSEL_MODE_TQC_PG;
      psel_pkg::RG_CSRC: wok = 1'b1;
      psel_pkg::RG_IFN:  wok = 1'b1;
      psel_pkg::RG_CTRL: wok = 1'b1;
      default:           wok = 1'b0;
    endcase
  end

  logic [31:0] speed_fb_r, cmd_raw_r, cmd_y_r, pos_r;
  logic        fb_valid_r, cmd_valid_r, dir_r, a_func_r, stopped_r;

  wire pending = (src_r != src_act_r) | (ppr_r != ppr_act_r) |
                 (fbt_r != fbt_act_r);

  always_comb
  begin
    rval = 32'h0000_0000;
    rok  = 1'b1;
    case (rsel)
      psel_pkg::RG_SRC:   rval = {16'h0000, src_r};
      psel_pkg::RG_PPR:   rval = {16'h0000, ppr_r};
      psel_pkg::RG_FBT:   rval = {16'h0000, fbt_r};
      psel_pkg::RG_CMDT:  rval = {16'h0000, cmdt_r};
      psel_pkg::RG_GNUM:  rval = {16'h0000, gnum_r};
      psel_pkg::RG_GDEN:  rval = {16'h0000, gden_r};
      psel_pkg::RG_FILT:  rval = {16'h0000, filt_r};
      psel_pkg::RG_CSRC:  rval = {16'h0000, csrc_r};
      psel_pkg::RG_IFN:   rval = {16'h0000, ifn_r};
      psel_pkg::RG_MODE:  rval = {16'h0000, mode_r};
      psel_pkg::RG_CTRL:  rval = 32'h0000_0000;
      psel_pkg::RG_STAT:  rval = {26'h0, stopped_r, cmd_path, fb_path,
                                  qd_bus.two_phase, dir_r, pending};
      psel_pkg::RG_SPEED: rval = fb_path ? speed_fb_r : cmd_y_r;
      psel_pkg::RG_POS:   rval = pos_r;
      default:            rok  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0000_0000;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      aw_have_r <= aw_nxt;
      w_have_r  <= w_nxt;
      awready_r <= ~aw_nxt;
      wready_r  <= ~w_nxt;
      if (aw_take)
        aw_addr_r <= awaddr;
      if (w_take)
      begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wok ? 2'h0 : 2'h2;
      end
      else if (bready)
        bvalid_r <= 1'b0;
      if (ar_take)
      begin
        rvalid_r  <= 1'b1;
        arready_r <= 1'b0;
        rdata_r   <= rval;
        rresp_r   <= rok ? 2'h0 : 2'h2;
      end
      else if (rvalid_r & rready)
      begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // The applied copies change only at reset or on an explicit restart.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      src_r     <= `PSEL_RST_SRC;
      ppr_r     <= `PSEL_RST_PPR;
      fbt_r     <= `PSEL_RST_FBT;
      cmdt_r    <= `PSEL_RST_CMDT;
      gnum_r    <= `PSEL_RST_GEAR;
      gden_r    <= `PSEL_RST_GEAR;
      filt_r    <= `PSEL_RST_FILT;
      csrc_r    <= `PSEL_RST_CSRC;
      ifn_r     <= `PSEL_RST_IFN;
      mode_r    <= `PSEL_RST_MODE;
      src_act_r <= `PSEL_RST_SRC;
      ppr_act_r <= `PSEL_RST_PPR;
      fbt_act_r <= `PSEL_RST_FBT;
    end
    else
    begin
      if (wr_do)
      begin
        case (wsel)
          psel_pkg::RG_SRC:  src_r  <= wv;
          psel_pkg::RG_PPR:  ppr_r  <= wv;
          psel_pkg::RG_FBT:  fbt_r  <= wv;
          psel_pkg::RG_CMDT: cmdt_r <= wv;
          psel_pkg::RG_GNUM: gnum_r <= wv;
          psel_pkg::RG_GDEN: gden_r <= wv;
          psel_pkg::RG_FILT: filt_r <= wv;
          psel_pkg::RG_CSRC: csrc_r <= wv;
          psel_pkg::RG_IFN:  ifn_r  <= wv;
          psel_pkg::RG_MODE: mode_r <= wv;
          default:           ;
        endcase
      end
      if (apply)
      begin
        src_act_r <= src_r;
        ppr_act_r <= ppr_r;
        fbt_act_r <= fbt_r;
      end
    end
  end

  // Pulse period measurement and the shared serial divider.
  logic [CW-1:0]          per_cnt_r;
  logic                   have_edge_r, recip_req_r, dv_fb_r;
  logic [5:0]             dv_cnt_r;
  logic [47:0]            dv_num_r, dv_quo_r;
  logic [63:0]            dv_den_r, dv_rem_r;
  logic [31:0]            recip_r;
  psel_pkg::psel_div_st_t dv_st_r;
  psel_pkg::psel_job_t    dv_job_r;

  wire [CW-1:0] per_now  = per_cnt_r + CW'(1);
  wire          per_full = per_cnt_r == CW'(STOP_CYC);
  wire          dv_idle  = dv_st_r == psel_pkg::DV_IDLE;
  wire          recip_go = dv_idle & recip_req_r & ~apply;
  wire          rate_go  = dv_idle & ~recip_req_r & step & have_edge_r &
                           ~apply & (fb_path | cmd_path);
  wire          dv_fb_nxt = fb_path;
  wire [15:0]   g_num    = dv_fb_nxt ? 16'h0001 : gnum_r;
  wire [15:0]   g_den    = dv_fb_nxt ? 16'h0001 : gden_r;
  // Hz x 100 = clock x 100 x num / (period x ppr x den).
  wire [47:0]   rate_num = `PSEL_CLK_HZ * `PSEL_CHZ_SCALE * 48'(g_num);
  wire [63:0]   rate_den = 64'(per_now) * 64'(ppr_act_r) * 64'(g_den);
  wire [63:0]   rem_sh   = {dv_rem_r[62:0], dv_num_r[47]};
  wire          rem_ge   = rem_sh >= dv_den_r;
  wire [47:0]   quo_nxt  = {dv_quo_r[46:0], rem_ge};
  wire [31:0]   dv_res   = (quo_nxt[47:32] != 16'h0000) ? 32'hFFFF_FFFF
                                                         : quo_nxt[31:0];
  wire          dv_done  = (dv_st_r == psel_pkg::DV_RUN) &&
                           (dv_cnt_r == 6'h2F);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      per_cnt_r   <= '0;
      have_edge_r <= 1'b0;
      stopped_r   <= 1'b1;
      pos_r       <= 32'h0000_0000;
      dir_r       <= 1'b1;
    end
    else if (apply)
    begin
      per_cnt_r   <= '0;
      have_edge_r <= 1'b0;
      stopped_r   <= 1'b1;
      pos_r       <= 32'h0000_0000;
    end
    else if (step)
    begin
      per_cnt_r   <= '0;
      have_edge_r <= 1'b1;
      stopped_r   <= 1'b0;
      dir_r       <= dir;
      pos_r       <= dir ? pos_r + 32'h1 : pos_r - 32'h1;
    end
    else if (per_full)
    begin
      have_edge_r <= 1'b0;
      stopped_r   <= 1'b1;
    end
    else
      per_cnt_r <= per_now;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dv_st_r     <= psel_pkg::DV_IDLE;
      dv_job_r    <= psel_pkg::JOB_RATE;
      dv_fb_r     <= 1'b0;
      dv_cnt_r    <= 6'h00;
      dv_num_r    <= 48'h0;
      dv_den_r    <= 64'h0;
      dv_rem_r    <= 64'h0;
      dv_quo_r    <= 48'h0;
      recip_req_r <= 1'b1;
      recip_r     <= 32'h0000_0000;
      speed_fb_r  <= 32'h0000_0000;
      cmd_raw_r   <= 32'h0000_0000;
    end
    else
    begin
      if (apply | (wr_do & (wsel == psel_pkg::RG_FILT)))
        recip_req_r <= 1'b1;
      else if (recip_go)
        recip_req_r <= 1'b0;
      case (dv_st_r)
        psel_pkg::DV_IDLE:
        begin
          dv_cnt_r <= 6'h00;
          dv_rem_r <= 64'h0;
          dv_quo_r <= 48'h0;
          if (recip_go)
          begin
            dv_st_r  <= psel_pkg::DV_RUN;
            dv_job_r <= psel_pkg::JOB_RECIP;
            dv_num_r <= `PSEL_RECIP_ONE;
            dv_den_r <= 64'(filt_r) * `PSEL_FILT_MS;
          end
          else if (rate_go)
          begin
            dv_st_r  <= psel_pkg::DV_RUN;
            dv_job_r <= psel_pkg::JOB_RATE;
            dv_fb_r  <= dv_fb_nxt;
            dv_num_r <= rate_num;
            dv_den_r <= rate_den;
          end
        end
        psel_pkg::DV_RUN:
        begin
          dv_cnt_r <= dv_cnt_r + 6'h01;
          dv_num_r <= {dv_num_r[46:0], 1'b0};
          dv_quo_r <= quo_nxt;
          dv_rem_r <= rem_ge ? rem_sh - dv_den_r : rem_sh;
          if (dv_done)
            dv_st_r <= psel_pkg::DV_IDLE;
        end
        default: dv_st_r <= psel_pkg::DV_IDLE;
      endcase
      if (dv_done & (dv_job_r == psel_pkg::JOB_RECIP))
        recip_r <= dv_res;
      else if (dv_done & dv_fb_r)
        speed_fb_r <= dv_res;
      else if (dv_done)
        cmd_raw_r <= dv_res;
      // A standing shaft gives no edges; report zero after the timeout.
      if (per_full & ~stopped_r)
      begin
        speed_fb_r <= 32'h0000_0000;
        cmd_raw_r  <= 32'h0000_0000;
      end
    end
  end

  // First-order lag on a 1 ms tick; tiny residual errors may not settle.
  logic [TW-1:0]      tick_r;
  wire                tick  = tick_r == TW'(FILT_TICK_CYC - 1);
  wire signed [33:0]  fdiff = $signed({2'b00, cmd_raw_r}) -
                              $signed({2'b00, cmd_y_r});
  wire signed [66:0]  fprod = fdiff * $signed({1'b0, recip_r});
  wire [33:0]         y_new = {2'b00, cmd_y_r} + 34'(fprod[57:24]);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tick_r      <= '0;
      cmd_y_r     <= 32'h0000_0000;
      fb_valid_r  <= 1'b0;
      cmd_valid_r <= 1'b0;
      a_func_r    <= 1'b1;
    end
    else
    begin
      tick_r <= tick ? '0 : tick_r + TW'(1);
      if (filt_r == 16'h0000)
        cmd_y_r <= cmd_raw_r;
      else if (tick)
        cmd_y_r <= y_new[31:0];
      fb_valid_r  <= fb_path & ~stopped_r;
      cmd_valid_r <= cmd_path;
      a_func_r    <= ~(qd_bus.en & ~qd_bus.two_phase);
    end
  end

  assign awready         = awready_r;
  assign wready          = wready_r;
  assign bvalid          = bvalid_r;
  assign bresp           = bresp_r;
  assign arready         = arready_r;
  assign rvalid          = rvalid_r;
  assign rdata           = rdata_r;
  assign rresp           = rresp_r;
  assign pulse_a_func_en = a_func_r;
  assign speed_fb_chz    = speed_fb_r;
  assign speed_fb_valid  = fb_valid_r;
  assign speed_cmd_chz   = cmd_y_r;
  assign speed_cmd_valid = cmd_valid_r;
  assign speed_dir       = dir_r;
endmodule : psel_top

// file: sim/psel_asserts.sv
`timescale 1ns/10ps
module psel_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        pulse_a_func_en,
  input wire logic [31:0] speed_fb_chz,
  input wire logic        speed_fb_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_B_DELAY: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  AST_B_RESP: assert property (bvalid
    |-> bresp inside {2'h0, 2'h2}) else $error("bad write response");
  AST_R_DELAY: assert property (arvalid && arready
    |=> rvalid) else $error("read answer late");
  AST_R_HOLD: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata)) else $error("read data moved");
  AST_R_BLOCK: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  AST_AW_BUSY: assert property (awvalid && awready
    |=> !awready) else $error("address taken while busy");
  AST_RST_VAL: assert property ($rose(rst_n) |-> !bvalid && !rvalid
    && pulse_a_func_en && speed_fb_chz == 32'h0)
    else $error("reset state wrong");
  COV_ERR: cover property (bvalid && bresp == 2'h2);
  COV_FB: cover property (speed_fb_valid);
  COV_SINGLE: cover property (!pulse_a_func_en);
endmodule : psel_asserts

bind psel_top psel_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .pulse_a_func_en(pulse_a_func_en),
  .speed_fb_chz(speed_fb_chz), .speed_fb_valid(speed_fb_valid));

// file: sim/psel_pulse_gen.sv
`timescale 1ns/10ps
module psel_pulse_gen #(
  parameter int QTR = 500
) (
  input  wire logic sys_clk,
  input  wire logic run,
  input  wire logic two_ph,
  input  wire logic fwd,
  output wire logic pulse_in_a,
  output wire logic pulse_in_b
);
  int         cnt_r = 0;
  logic [1:0] ph_r  = 2'h0;
  // A quarter of 500 cycles gives 10 kHz, kept under the input limit.
  always_ff @(posedge sys_clk)
    if (run)
    begin
      cnt_r <= (cnt_r == QTR - 1) ? 0 : cnt_r + 1;
      if (cnt_r == QTR - 1)
        ph_r <= ph_r + 2'h1;
    end
  // One pulse is a full A/B cycle; A drives the first terminal.
  assign pulse_in_a = two_ph & (fwd ? ^ph_r : ph_r[1]);
  assign pulse_in_b = (two_ph & ~fwd) ? ^ph_r : ph_r[1];
endmodule : psel_pulse_gen

// file: sim/tb_pulse_input_selector.sv
`timescale 1ns/10ps
`include "psel_defs.svh"
module tb_pulse_input_selector;
  logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pa, pb;
  logic        a_en, fb_v, cmd_v, dir, run, two_ph, fwd;
  logic        cs, pb_q;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, fb, cmd;
  logic [1:0]  bresp, rresp;
  int          fail_count, n_tests;
  psel_top #(.FILT_TICK_CYC(20), .STOP_CYC(20000)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pulse_in_a(pa),
    .pulse_in_b(pb), .card_step(cs), .card_dir(1'b1),
    .pulse_a_func_en(a_en), .speed_fb_chz(fb), .speed_fb_valid(fb_v),
    .speed_cmd_chz(cmd), .speed_cmd_valid(cmd_v), .speed_dir(dir));
  psel_pulse_gen gen_u (.sys_clk(sys_clk), .run(run), .two_ph(two_ph),
    .fwd(fwd), .pulse_in_a(pa), .pulse_in_b(pb));
  // The card in slot 1 gives one step per rise of the second pin.
  always_ff @(posedge sys_clk)
  begin
    pb_q <= pb;
    cs   <= pb & ~pb_q;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] i, input logic [15:0] d,
    input logic [1:0] e);
    bit a;
    bit w;
    a = 0;
    w = 0;
    @(posedge sys_clk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready) a = 1;
      if (wready) w = 1;
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(a && w));
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [11:0] i, input logic [15:0] d,
    input logic [1:0] e);
    @(posedge sys_clk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    rready <= 1'b0;
    chk("rdata", rdata, {16'h0000, d});
    chk("rresp", {30'h0, rresp}, {30'h0, e});
  endtask : rd
  task automatic end_of_test;
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Each phase settles over four pulse periods of 2000 cycles.
  task automatic settle;
    repeat (8000) @(posedge sys_clk);
  endtask : settle
  initial
  begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, run, two_ph} = 0;
    {awaddr, araddr, wdata, fail_count, n_tests} = 0;
    fwd = 1;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`PSEL_IDX_SRC, 16'h0000, 2'h0);
    rd(`PSEL_IDX_PPR, 16'h0258, 2'h0);
    wr(`PSEL_IDX_PPR, 16'h4E21, 2'h2);
    wr(`PSEL_IDX_PPR, 16'h0000, 2'h2);
    wr(`PSEL_IDX_SRC, 16'h0003, 2'h2);
    wr(`PSEL_IDX_STAT, 16'h0001, 2'h2);
    rd(12'hA30, 16'h0000, 2'h2);
    wr(`PSEL_IDX_PPR, 16'h03E8, 2'h0);
    rd(`PSEL_IDX_PPR, 16'h03E8, 2'h0);
    wr(`PSEL_IDX_SRC, 16'h0005, 2'h0);
    wr(`PSEL_IDX_FBT, 16'h0005, 2'h0);
    run <= 1'b1;
    settle();
    chk("fb_valid", {31'h0, fb_v}, 32'h0);
    wr(`PSEL_IDX_CTRL, 16'h0001, 2'h0);
    settle();
    chk("fb single", fb, 32'h3E8);
    chk("a_en single", {31'h0, a_en}, 32'h0);
    chk("fb_valid on", {31'h0, fb_v}, 32'h1);
    rd(`PSEL_IDX_SPEED, 16'h03E8, 2'h0);
    rd(`PSEL_IDX_STAT, 16'h000A, 2'h0);
    two_ph <= 1'b1;
    wr(`PSEL_IDX_FBT, 16'h0001, 2'h0);
    wr(`PSEL_IDX_CTRL, 16'h0001, 2'h0);
    settle();
    chk("fb two", fb, 32'h3E8);
    chk("dir fwd", {31'h0, dir}, 32'h1);
    chk("a_en two", {31'h0, a_en}, 32'h1);
    fwd <= 1'b0;
    settle();
    chk("dir rev", {31'h0, dir}, 32'h0);
    run <= 1'b0;
    repeat (24000) @(posedge sys_clk);
    chk("fb stop", fb, 32'h0);
    wr(`PSEL_IDX_FBT, 16'h0000, 2'h0);
    wr(`PSEL_IDX_CSRC, 16'h0004, 2'h0);
    wr(`PSEL_IDX_CMDT, 16'h0005, 2'h0);
    wr(`PSEL_IDX_GNUM, 16'h0002, 2'h0);
    wr(`PSEL_IDX_CTRL, 16'h0001, 2'h0);
    two_ph <= 1'b0;
    run <= 1'b1;
    settle();
    chk("cmd", cmd, 32'h7D0);
    chk("cmd_valid", {31'h0, cmd_v}, 32'h1);
    wr(`PSEL_IDX_SRC, 16'h0001, 2'h0);
    wr(`PSEL_IDX_CTRL, 16'h0001, 2'h0);
    settle();
    chk("fb card", fb, 32'h3E8);
    chk("cmd_v card", {31'h0, cmd_v}, 32'h0);
    wr(`PSEL_IDX_SRC, 16'h0000, 2'h0);
    wr(`PSEL_IDX_CMDT, 16'h0001, 2'h0);
    wr(`PSEL_IDX_PPR, 16'h07D0, 2'h0);
    wr(`PSEL_IDX_CTRL, 16'h0001, 2'h0);
    two_ph <= 1'b1;
    settle();
    chk("cmd two", cmd, 32'h3E8);
    chk("a_en cmd two", {31'h0, a_en}, 32'h1);
    end_of_test();
  end
endmodule : tb_pulse_input_selector
